// ==== cms_pkg.sv ====
// Shared constants and types for the alternating-pattern margin sequencer
package cms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and counter sizing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TMR_W         = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Margin timing, as printed
  localparam int STROBE_HOLD_AFTER_SELECT_NS  = 100;
  localparam int STROBE_SETUP_TO_ENABLE_NS    = 0;
  localparam int ENABLE_TO_VOLTAGE_SETUP_US   = 50;
  localparam int ENABLE_TO_RECALL_SETUP_US    = 250;
  localparam int VOLTAGE_HOLD_AFTER_RECALL_NS = 0;
  localparam int SELECT_HOLD_AFTER_VOLTAGE_NS = 100;

  // Device cycle times; plain defaults, set per part
  localparam int WRITE_PULSE_NS  = 100;
  localparam int READ_ACCESS_NS  = 250;
  localparam int STORE_PULSE_NS  = 1000;
  localparam int STORE_TIME_US   = 10000;
  localparam int RECALL_PULSE_NS = 1000;
  localparam int RECALL_TIME_US  = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts: least times round up; only strobe setup and voltage hold are clamped to one cycle
  localparam int STROBE_HOLD_CYC =
    (STROBE_HOLD_AFTER_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_SETUP_CYC_RAW =
    (STROBE_SETUP_TO_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_SETUP_CYC =
    (STROBE_SETUP_CYC_RAW < 1) ? 1 : STROBE_SETUP_CYC_RAW;
  localparam int VOLT_SETUP_CYC =
    (ENABLE_TO_VOLTAGE_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_SETUP_CYC =
    (ENABLE_TO_RECALL_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VOLT_HOLD_CYC_RAW =
    (VOLTAGE_HOLD_AFTER_RECALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VOLT_HOLD_CYC =
    (VOLT_HOLD_CYC_RAW < 1) ? 1 : VOLT_HOLD_CYC_RAW;
  localparam int SELECT_HOLD_CYC =
    (SELECT_HOLD_AFTER_VOLTAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_PULSE_CYC =
    (STORE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_TIME_CYC =
    (STORE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_PULSE_CYC =
    (RECALL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_TIME_CYC =
    (RECALL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern and search constants
  localparam logic [3:0] PATTERN_START   = 4'hA;
  localparam logic [7:0] LAST_ADDR_64    = 8'h3F;
  localparam logic [7:0] LAST_ADDR_128   = 8'h7F;
  localparam logic [7:0] LAST_ADDR_256   = 8'hFF;
  localparam int         ROW_BITS_SMALL  = 3;
  localparam int         ROW_BITS_LARGE  = 4;
  localparam int         LIMIT_W         = 10;
  localparam logic [9:0] FAIL_LIMIT_INIT = 10'h200;
  localparam logic [9:0] PASS_LIMIT_INIT = 10'h000;
  localparam logic [3:0] LAST_ITERATION  = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    VAR_64X4  = 2'h0,
    VAR_128X4 = 2'h1,
    VAR_256X4 = 2'h2
  } cms_variant_type;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h00,
    ST_WR_SET   = 5'h01,
    ST_WR_PULSE = 5'h03,
    ST_WR_END   = 5'h02,
    ST_STO_PUL  = 5'h06,
    ST_STO_WAIT = 5'h07,
    ST_RCL_PUL  = 5'h05,
    ST_RCL_WAIT = 5'h04,
    ST_RD_SET   = 5'h0C,
    ST_RD_SMPL  = 5'h0D,
    ST_M_SEL    = 5'h0F,
    ST_M_ENA    = 5'h0E,
    ST_M_VOLT   = 5'h0A,
    ST_M_RCL    = 5'h0B,
    ST_M_RCLW   = 5'h09,
    ST_M_VOFF   = 5'h08,
    ST_M_END    = 5'h18,
    ST_DONE     = 5'h19
  } cms_state_type;

  typedef enum logic [3:0] {
    SP_CB_WR  = 4'h0,
    SP_STORE  = 4'h1,
    SP_RECALL = 4'h3,
    SP_VERIFY = 4'h2,
    SP_ICB_WR = 4'h6,
    SP_MARGIN = 4'h7,
    SP_MREAD  = 4'h5,
    SP_CB_WR2 = 4'h4,
    SP_STORE2 = 4'hC
  } cms_step_type;

endpackage

// ==== cms_pattern.sv ====
// Address-to-nibble map of the alternating pattern for each array variant
`timescale 1ns/1ps
`default_nettype none
module cms_pattern
  import cms_pkg::*;
(
  // Walk position
  input  wire cms_variant_type variant,
  input  wire logic [7:0]      addr,
  input  wire logic            invert,
  // Pattern
  output logic [3:0]           data,
  output logic                 last
);

  logic row_lsb;
  logic col_lsb;
  logic parity;

  // Row bits sit below column bits, so the column lsb moves with the variant
  assign row_lsb = addr[0];
  assign col_lsb = (variant == VAR_256X4) ? addr[ROW_BITS_LARGE]
                                          : addr[ROW_BITS_SMALL];
  // Flip per row, repeat at a column start: even row counts make this parity
  assign parity  = row_lsb ^ col_lsb ^ invert;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bit
      assign data[gi] = PATTERN_START[gi] ^ parity;
    end
  endgenerate

  always_comb begin
    case (variant)
      VAR_64X4:  last = (addr == LAST_ADDR_64);
      VAR_128X4: last = (addr == LAST_ADDR_128);
      default:   last = (addr == LAST_ADDR_256);
    endcase
  end

endmodule
`default_nettype wire

// ==== cms_seq.sv ====
// Checkerboard write, store, recall and margin search sequencer
// Notes on behaviour
// - 64x4: row A0-A2, column A3-A5
// - 128x4: row A0-A2, column A3-A6
// - 256x4: row A0-A3, column A4-A7
// - Pass starts at address zero with 1010
// - Each address step inverts the nibble
// - New column repeats previous nibble
// - Inverse pattern: same walk, every nibble inverted
// - Store pattern to nonvolatile array after write
// - Recall then read every location to verify
// - Store again between ones and zeros campaigns
// - Strobe held 100 ns after select, before enable
// - Enable leads margin voltage by 50 us
// - Enable leads margin recall by 250 us
// - Voltage stays until recall cycle ends
// - Select held 100 ns after voltage removed
// - Fill inverse pattern before each margin recall
// - Midpoint of limits; pass/fail replaces that limit
// - Nine iterations; result is final midpoint
`timescale 1ns/1ps
`default_nettype none
module cms_seq
  import cms_pkg::*;
#(
  parameter int STORE_WAIT_CYC  = STORE_TIME_CYC,
  parameter int RCL_SETUP_CYC   = RECALL_SETUP_CYC
)
(
  // Clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  // Command
  input  wire logic             START,
  input  wire cms_variant_type  VARIANT,
  // Status
  output logic                  BUSY,
  output logic                  DONE,
  output logic                  VERIFY_PASS,
  output logic [LIMIT_W-1:0]    ONES_RESULT,
  output logic [LIMIT_W-1:0]    ZEROS_RESULT,
  // Memory pins
  output logic [7:0]            ADDR,
  input  wire logic [3:0]       DQ_IN,
  output logic [3:0]            DQ_OUT,
  output logic                  DQ_OE_N,
  output logic                  CS_N,
  output logic                  WE_N,
  output logic                  STORE_RECALL_N,
  output logic                  ARRAY_RECALL_N,
  // Margin supply controls
  output logic                  MARGIN_ENABLE_PIN,
  output logic                  MARGIN_VOLTAGE_PIN,
  output logic [LIMIT_W-1:0]    MARGIN_CODE,
  output logic                  MARGIN_NEGATIVE
);

  cms_state_type       state_r;
  cms_state_type       state_nxt;
  cms_step_type        step_r;
  cms_step_type        step_nxt;
  cms_variant_type     variant_r;
  logic [7:0]          addr_r;
  logic [7:0]          addr_nxt;
  logic [3:0]          iter_r;
  logic [3:0]          iter_nxt;
  logic                zeros_r;
  logic                zeros_nxt;
  logic [TMR_W-1:0]    tmr_r;
  logic                tmr_zero;
  logic                pass_end;
  logic [3:0]          pat_data;
  logic                pat_last;
  logic                mism_r;
  logic                mism_now;
  logic [LIMIT_W-1:0]  pass_lim_r;
  logic [LIMIT_W-1:0]  fail_lim_r;
  logic [LIMIT_W:0]    lim_sum;
  logic [LIMIT_W-1:0]  mid;
  logic [LIMIT_W:0]    fin_sum;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern source

  cms_pattern u_pattern (
    .variant (variant_r),
    .addr    (addr_r),
    .invert  (step_r == SP_ICB_WR),
    .data    (pat_data),
    .last    (pat_last)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State dwell times; pins follow the state one cycle later, so every
  // interval between pin edges equals the dwell of the states between them

  function automatic logic [TMR_W-1:0] dwell(input cms_state_type st);
    int n;
    case (st)
      ST_WR_PULSE: n = WRITE_PULSE_CYC;
      ST_RD_SET:   n = READ_ACCESS_CYC;
      ST_STO_PUL:  n = STORE_PULSE_CYC;
      ST_STO_WAIT: n = STORE_WAIT_CYC;
      ST_RCL_PUL:  n = RECALL_PULSE_CYC;
      ST_RCL_WAIT: n = RECALL_TIME_CYC;
      ST_M_SEL:    n = STROBE_HOLD_CYC;
      ST_M_ENA:    n = VOLT_SETUP_CYC;
      ST_M_VOLT:   n = RCL_SETUP_CYC - VOLT_SETUP_CYC;
      ST_M_RCL:    n = RECALL_PULSE_CYC;
      ST_M_RCLW:   n = RECALL_TIME_CYC + VOLT_HOLD_CYC;
      ST_M_VOFF:   n = SELECT_HOLD_CYC;
      default:     n = 1;
    endcase
    dwell = TMR_W'(n - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequence control

  assign tmr_zero = (tmr_r == '0);

  always_comb begin
    state_nxt = state_r;
    step_nxt  = step_r;
    addr_nxt  = addr_r;
    iter_nxt  = iter_r;
    zeros_nxt = zeros_r;
    pass_end  = 1'b0;
    if (state_r == ST_IDLE) begin
      if (START) begin
        step_nxt  = SP_CB_WR;
        addr_nxt  = 8'h00;
        iter_nxt  = 4'h0;
        zeros_nxt = 1'b0;
        state_nxt = ST_WR_SET;
      end
    end else if (tmr_zero) begin
      case (state_r)
        ST_WR_SET:   state_nxt = ST_WR_PULSE;
        ST_WR_PULSE: state_nxt = ST_WR_END;
        ST_WR_END: begin
          if (pat_last) begin
            addr_nxt = 8'h00;
            pass_end = 1'b1;
          end else begin
            addr_nxt  = addr_r + 8'h01;
            state_nxt = ST_WR_SET;
          end
        end
        ST_RD_SET:   state_nxt = ST_RD_SMPL;
        ST_RD_SMPL: begin
          if (pat_last) begin
            addr_nxt = 8'h00;
            pass_end = 1'b1;
          end else begin
            addr_nxt  = addr_r + 8'h01;
            state_nxt = ST_RD_SET;
          end
        end
        ST_STO_PUL:  state_nxt = ST_STO_WAIT;
        ST_STO_WAIT: pass_end  = 1'b1;
        ST_RCL_PUL:  state_nxt = ST_RCL_WAIT;
        ST_RCL_WAIT: pass_end  = 1'b1;
        ST_M_SEL:    state_nxt = ST_M_ENA;
        ST_M_ENA:    state_nxt = ST_M_VOLT;
        ST_M_VOLT:   state_nxt = ST_M_RCL;
        ST_M_RCL:    state_nxt = ST_M_RCLW;
        ST_M_RCLW:   state_nxt = ST_M_VOFF;
        ST_M_VOFF:   state_nxt = ST_M_END;
        ST_M_END:    pass_end  = 1'b1;
        ST_DONE:     state_nxt = ST_IDLE;
        default:     state_nxt = ST_IDLE;
      endcase
    end
    if (pass_end) begin
      case (step_r)
        SP_CB_WR: begin
          step_nxt  = SP_STORE;
          state_nxt = ST_STO_PUL;
        end
        SP_STORE: begin
          step_nxt  = SP_RECALL;
          state_nxt = ST_RCL_PUL;
        end
        SP_RECALL: begin
          step_nxt  = SP_VERIFY;
          state_nxt = ST_RD_SET;
        end
        SP_VERIFY: begin
          step_nxt  = SP_ICB_WR;
          state_nxt = ST_WR_SET;
        end
        SP_ICB_WR: begin
          step_nxt  = SP_MARGIN;
          state_nxt = ST_M_SEL;
        end
        SP_MARGIN: begin
          step_nxt  = SP_MREAD;
          state_nxt = ST_RD_SET;
        end
        SP_MREAD: begin
          if (iter_r == LAST_ITERATION) begin
            iter_nxt = 4'h0;
            if (!zeros_r) begin
              zeros_nxt = 1'b1;
              step_nxt  = SP_CB_WR2;
              state_nxt = ST_WR_SET;
            end else begin
              state_nxt = ST_DONE;
            end
          end else begin
            iter_nxt  = iter_r + 4'h1;
            step_nxt  = SP_ICB_WR;
            state_nxt = ST_WR_SET;
          end
        end
        SP_CB_WR2: begin
          step_nxt  = SP_STORE2;
          state_nxt = ST_STO_PUL;
        end
        SP_STORE2: begin
          step_nxt  = SP_ICB_WR;
          state_nxt = ST_WR_SET;
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_r <= ST_IDLE;
      step_r  <= SP_CB_WR;
      addr_r  <= 8'h00;
      iter_r  <= 4'h0;
      zeros_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r  <= step_nxt;
      addr_r  <= addr_nxt;
      iter_r  <= iter_nxt;
      zeros_r <= zeros_nxt;
    end
  end

  // Variant is caught at start so a change mid-run cannot tear the walk
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      variant_r <= VAR_64X4;
    end else if (state_r == ST_IDLE && START) begin
      variant_r <= VARIANT;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      tmr_r <= dwell(state_nxt);
    end else if (!tmr_zero) begin
      tmr_r <= tmr_r - TMR_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back compare and binary search

  assign mism_now = (DQ_IN != pat_data) | ((addr_r != 8'h00) & mism_r);
  assign lim_sum  = {1'b0, pass_lim_r} + {1'b0, fail_lim_r};
  assign mid      = lim_sum[LIMIT_W:1];
  assign fin_sum  = mism_now ? ({1'b0, pass_lim_r} + {1'b0, mid})
                             : ({1'b0, mid} + {1'b0, fail_lim_r});

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mism_r      <= 1'b0;
      VERIFY_PASS <= 1'b0;
    end else if (state_r == ST_RD_SMPL && tmr_zero) begin
      mism_r <= mism_now;
      if (pat_last && step_r == SP_VERIFY) begin
        VERIFY_PASS <= !mism_now;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pass_lim_r   <= PASS_LIMIT_INIT;
      fail_lim_r   <= FAIL_LIMIT_INIT;
      ONES_RESULT  <= '0;
      ZEROS_RESULT <= '0;
    end else if (step_r == SP_VERIFY || step_r == SP_CB_WR2) begin
      pass_lim_r <= PASS_LIMIT_INIT;
      fail_lim_r <= FAIL_LIMIT_INIT;
    end else if (step_r == SP_MREAD && state_r == ST_RD_SMPL
                 && tmr_zero && pat_last) begin
      if (mism_now) begin
        fail_lim_r <= mid;
      end else begin
        pass_lim_r <= mid;
      end
      if (iter_r == LAST_ITERATION) begin
        if (zeros_r) begin
          ZEROS_RESULT <= fin_sum[LIMIT_W:1];
        end else begin
          ONES_RESULT <= fin_sum[LIMIT_W:1];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, one register stage behind the state

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ADDR               <= 8'h00;
      DQ_OUT             <= 4'h0;
      DQ_OE_N            <= 1'b1;
      CS_N               <= 1'b1;
      WE_N               <= 1'b1;
      STORE_RECALL_N     <= 1'b1;
      ARRAY_RECALL_N     <= 1'b1;
      MARGIN_ENABLE_PIN  <= 1'b0;
      MARGIN_VOLTAGE_PIN <= 1'b0;
    end else begin
      ADDR    <= addr_r;
      DQ_OUT  <= pat_data;
      DQ_OE_N <= !(state_r == ST_WR_SET || state_r == ST_WR_PULSE
                   || state_r == ST_WR_END);
      CS_N    <= !(state_r == ST_WR_SET || state_r == ST_WR_PULSE
                   || state_r == ST_RD_SET || state_r == ST_RD_SMPL
                   || state_r == ST_M_SEL || state_r == ST_M_ENA
                   || state_r == ST_M_VOLT || state_r == ST_M_RCL
                   || state_r == ST_M_RCLW || state_r == ST_M_VOFF);
      // Margin strobe goes low with select and stays low until release; a write strobes in ST_WR_PULSE only
      WE_N    <= !(state_r == ST_WR_PULSE || state_r == ST_M_SEL
                   || state_r == ST_M_ENA || state_r == ST_M_VOLT
                   || state_r == ST_M_RCL || state_r == ST_M_RCLW
                   || state_r == ST_M_VOFF);
      STORE_RECALL_N    <= !(state_r == ST_STO_PUL);
      ARRAY_RECALL_N    <= !(state_r == ST_RCL_PUL || state_r == ST_M_RCL);
      MARGIN_ENABLE_PIN <= (state_r == ST_M_ENA || state_r == ST_M_VOLT
                            || state_r == ST_M_RCL || state_r == ST_M_RCLW
                            || state_r == ST_M_VOFF);
      MARGIN_VOLTAGE_PIN <= (state_r == ST_M_VOLT || state_r == ST_M_RCL
                             || state_r == ST_M_RCLW);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      MARGIN_CODE     <= '0;
      MARGIN_NEGATIVE <= 1'b0;
      BUSY            <= 1'b0;
      DONE            <= 1'b0;
    end else begin
      MARGIN_CODE     <= mid;
      MARGIN_NEGATIVE <= zeros_r;
      BUSY            <= (state_r != ST_IDLE);
      DONE            <= (state_r == ST_DONE);
    end
  end

endmodule
`default_nettype wire

// ==== cms_seq_monitor.sv ====
// Port checker for the margin sequencer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module cms_seq_monitor
  import cms_pkg::*;
#(
  parameter int RCL_SETUP_CYC = RECALL_SETUP_CYC
)
(
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST,
  // Command and status
  input wire logic       START,
  input wire logic       BUSY,
  input wire logic       DONE,
  // Memory pins
  input wire logic [3:0] DQ_OUT,
  input wire logic       DQ_OE_N,
  input wire logic       CS_N,
  input wire logic       WE_N,
  input wire logic       STORE_RECALL_N,
  input wire logic       ARRAY_RECALL_N,
  input wire logic       MARGIN_ENABLE_PIN,
  input wire logic       MARGIN_VOLTAGE_PIN
);
  default clocking mcb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // Enable age; a counter because the setup spans thousands of cycles
  logic [15:0] en_cnt_r;
  always_ff @(posedge CLK_SYS) begin
    if (RST || !MARGIN_ENABLE_PIN) en_cnt_r <= 16'h0000;
    else if (en_cnt_r != 16'hFFFF) en_cnt_r <= en_cnt_r + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_strobe_before_enable: assert property ($rose(MARGIN_ENABLE_PIN) |->
    !WE_N && !$past(WE_N, 4) && !$past(CS_N, 4))
    else $error("strobe not set up before margin enable");
  a_enable_to_voltage: assert property ($rose(MARGIN_VOLTAGE_PIN) |->
    int'(en_cnt_r) >= VOLT_SETUP_CYC)
    else $error("margin voltage too soon after enable");
  a_enable_to_recall: assert property (
    $fell(ARRAY_RECALL_N) && MARGIN_ENABLE_PIN |->
    int'(en_cnt_r) >= RCL_SETUP_CYC)
    else $error("margin recall too soon after enable");
  a_voltage_over_recall: assert property (
    MARGIN_ENABLE_PIN && !ARRAY_RECALL_N |->
    MARGIN_VOLTAGE_PIN ##1 MARGIN_VOLTAGE_PIN)
    else $error("margin voltage removed during recall");
  a_select_after_voltage: assert property (
    $fell(MARGIN_VOLTAGE_PIN) |-> (!CS_N)[*4])
    else $error("select released too soon after voltage");
  a_write_frame: assert property ($fell(WE_N) && !$past(CS_N) |->
    (!WE_N && !DQ_OE_N && $stable(DQ_OUT))[*4] ##1 (WE_N && !DQ_OE_N))
    else $error("write strobe or data frame wrong");
  a_store_pulse: assert property ($fell(STORE_RECALL_N) |->
    ##39 !STORE_RECALL_N ##1 STORE_RECALL_N)
    else $error("store pulse width wrong");
  a_done_pulse_end: assert property (DONE |=> !DONE ##[0:1] !BUSY)
    else $error("done pulse or busy release wrong");
  a_start_to_busy: assert property ($rose(BUSY) |->
    $past(START, 2) || $past(START, 3))
    else $error("busy rose without a start");
endmodule

bind cms_seq cms_seq_monitor #(.RCL_SETUP_CYC(RCL_SETUP_CYC))
  u_cms_seq_monitor (
  .CLK_SYS(CLK_SYS), .RST(RST), .START(START), .BUSY(BUSY), .DONE(DONE),
  .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .CS_N(CS_N), .WE_N(WE_N),
  .STORE_RECALL_N(STORE_RECALL_N), .ARRAY_RECALL_N(ARRAY_RECALL_N),
  .MARGIN_ENABLE_PIN(MARGIN_ENABLE_PIN),
  .MARGIN_VOLTAGE_PIN(MARGIN_VOLTAGE_PIN));
`default_nettype wire

// ==== cms_nvram_model.sv ====
// Behavioural nibble-wide nonvolatile RAM, driven only by its pins
`timescale 1ns/1ps
`default_nettype none
module cms_nvram_model
  import cms_pkg::*;
#(
  parameter int ONES_LIM  = 300,
  parameter int ZEROS_LIM = 77
)
(
  // Address and data
  input  wire logic [7:0]         addr,
  input  wire logic [3:0]         dq_out,
  input  wire logic               dq_oe_n,
  output logic [3:0]              dq_in,
  // Controls
  input  wire logic               cs_n,
  input  wire logic               we_n,
  input  wire logic               store_recall_n,
  input  wire logic               array_recall_n,
  // Margin supply
  input  wire logic               margin_enable,
  input  wire logic               margin_voltage,
  input  wire logic [LIMIT_W-1:0] margin_code,
  input  wire logic               margin_negative
);
  logic [3:0] sram [256];
  logic [3:0] nvm  [256];
  logic [3:0] last_q = 4'h0;
  logic       rd_en;
  logic       sel_q = 1'b0;

  // Released bus shows the complement, so a stale sample never matches
  assign rd_en = !cs_n && we_n && dq_oe_n && !margin_enable;
  assign dq_in = rd_en ? sram[addr] : ~last_q;
  always @* if (rd_en) last_q = sram[addr];

  // Select and strobe rise together, so select is judged as the strobe falls
  always @(negedge we_n) sel_q = !cs_n;
  always @(posedge we_n) begin
    if (sel_q && !dq_oe_n && !margin_enable) sram[addr] = dq_out;
  end
  always @(negedge store_recall_n) begin
    for (int i = 0; i < 256; i++) nvm[i] = sram[i];
  end
  // A margin recall above the cell threshold leaves the old contents
  always @(negedge array_recall_n) begin
    if (!margin_voltage ||
        int'(margin_code) <= (margin_negative ? ZEROS_LIM : ONES_LIM))
      for (int i = 0; i < 256; i++) sram[i] = nvm[i];
  end
endmodule
`default_nettype wire

// ==== checkerboard_margin_sequencer_bench.sv ====
// Self-checking bench for the margin sequencer against the memory model
`timescale 1ns/1ps
`default_nettype none
module checkerboard_margin_sequencer_bench
  import cms_pkg::*;
;
  localparam int ONES_LIM  = 300;
  localparam int ZEROS_LIM = 77;
  typedef struct {
    cms_variant_type var_sel;
    int              rb;
    logic [7:0]      last_a;
    bit              full;
  } cms_row_type;
  cms_row_type rows [3] = '{'{VAR_128X4, 3, LAST_ADDR_128, 1'b0},
    '{VAR_256X4, 4, LAST_ADDR_256, 1'b0}, '{VAR_64X4, 3, LAST_ADDR_64, 1'b1}};

  logic CLK_SYS = 1'b0, RST = 1'b1, START = 1'b0;
  cms_variant_type VARIANT = VAR_64X4;
  logic BUSY, DONE, VERIFY_PASS, DQ_OE_N, CS_N, WE_N, MARGIN_NEGATIVE;
  logic STORE_RECALL_N, ARRAY_RECALL_N, MARGIN_ENABLE_PIN, MARGIN_VOLTAGE_PIN;
  logic [LIMIT_W-1:0] ONES_RESULT, ZEROS_RESULT, MARGIN_CODE;
  logic [7:0] ADDR;
  logic [3:0] DQ_IN, DQ_OUT;
  int miscompares = 0, cmp_count = 0;
  int cur_n = 64, cur_rb = 3, wr_cnt, stores, mrc, pl, fl, mid, ones_exp;
  int zeros_exp;
  logic we_q = 1'b1, sr_q = 1'b1, ar_q = 1'b1;

  always #(CLK_PERIOD_NS / 2.0) CLK_SYS = ~CLK_SYS;

  cms_seq #(.STORE_WAIT_CYC(8), .RCL_SETUP_CYC(2100)) u_cms_seq (
    .CLK_SYS(CLK_SYS), .RST(RST), .START(START), .VARIANT(VARIANT),
    .BUSY(BUSY), .DONE(DONE), .VERIFY_PASS(VERIFY_PASS),
    .ONES_RESULT(ONES_RESULT), .ZEROS_RESULT(ZEROS_RESULT), .ADDR(ADDR),
    .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .CS_N(CS_N),
    .WE_N(WE_N), .STORE_RECALL_N(STORE_RECALL_N),
    .ARRAY_RECALL_N(ARRAY_RECALL_N), .MARGIN_ENABLE_PIN(MARGIN_ENABLE_PIN),
    .MARGIN_VOLTAGE_PIN(MARGIN_VOLTAGE_PIN), .MARGIN_CODE(MARGIN_CODE),
    .MARGIN_NEGATIVE(MARGIN_NEGATIVE));
  cms_nvram_model #(.ONES_LIM(ONES_LIM), .ZEROS_LIM(ZEROS_LIM))
    u_cms_nvram_model (
    .addr(ADDR), .dq_out(DQ_OUT), .dq_oe_n(DQ_OE_N), .dq_in(DQ_IN),
    .cs_n(CS_N), .we_n(WE_N), .store_recall_n(STORE_RECALL_N),
    .array_recall_n(ARRAY_RECALL_N), .margin_enable(MARGIN_ENABLE_PIN),
    .margin_voltage(MARGIN_VOLTAGE_PIN), .margin_code(MARGIN_CODE),
    .margin_negative(MARGIN_NEGATIVE));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic exp, input logic got);
    chk_val({15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic close_out();
    $display("miscompares %0d of %0d compares", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_idle();
    chk_val(16'h001F, {11'h000, CS_N, WE_N, STORE_RECALL_N, ARRAY_RECALL_N,
      DQ_OE_N});
    chk_val(16'h0000, {4'h0, ADDR, MARGIN_ENABLE_PIN, MARGIN_VOLTAGE_PIN,
      BUSY, DONE});
  endtask
  function automatic logic [3:0] exp_nib(int a, bit inv);
    logic [7:0] av;
    av = a[7:0];
    return 4'hA ^ {4{av[0] ^ av[cur_rb]}} ^ {4{inv}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin observer: pins are read before this edge's updates land
  always @(posedge CLK_SYS) begin
    if (RST) begin
      wr_cnt = 0; stores = 0; mrc = 0; pl = 0; fl = 512;
    end else begin
      // Strobe and select rise together; the data drive still stands
      if (!we_q && WE_N === 1'b1 && DQ_OE_N === 1'b0 &&
          MARGIN_ENABLE_PIN === 1'b0) begin
        chk_val(16'(wr_cnt % cur_n), {8'h00, ADDR});
        chk_val(16'(exp_nib(wr_cnt % cur_n, (wr_cnt / cur_n) % 10 != 0)),
          {12'h000, DQ_OUT});
        wr_cnt++;
      end
      if (sr_q && STORE_RECALL_N === 1'b0) begin
        chk_val(16'(stores == 0 ? cur_n : 11 * cur_n), 16'(wr_cnt));
        chk_val(16'(stores == 0 ? 0 : 9), 16'(mrc));
        stores++;
      end
      if (ar_q && ARRAY_RECALL_N === 1'b0) begin
        if (MARGIN_ENABLE_PIN === 1'b1) begin
          chk_val(16'(cur_n * (mrc + 2 + (mrc >= 9))), 16'(wr_cnt));
          chk_bit(mrc >= 9, MARGIN_NEGATIVE);
          if (mrc == 9) begin
            pl = 0; fl = 512;
          end
          mid = (pl + fl) / 2;
          chk_val(16'(mid), {6'h00, MARGIN_CODE});
          if (mid <= (mrc < 9 ? ONES_LIM : ZEROS_LIM)) pl = mid;
          else fl = mid;
          if (mrc == 8) ones_exp = (pl + fl) / 2;
          if (mrc == 17) zeros_exp = (pl + fl) / 2;
          mrc++;
        end else begin
          chk_val(16'(cur_n), 16'(wr_cnt));
        end
      end
    end
    we_q = WE_N; sr_q = STORE_RECALL_N; ar_q = ARRAY_RECALL_N;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int r = 0; r < 3; r++) begin
      RST <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      cur_n = int'(rows[r].last_a) + 1;
      cur_rb = rows[r].rb;
      repeat (20) @(posedge CLK_SYS);
      RST <= 1'b0;
      VARIANT <= rows[r].var_sel;
      @(posedge CLK_SYS);
      @(posedge CLK_SYS);
      chk_val(16'h0100, {6'h00, MARGIN_CODE});
      START <= 1'b1;
      @(posedge CLK_SYS);
      START <= 1'b0;
      if (rows[r].full) begin
        // Second start while busy must not restart the walk
        repeat (200) @(posedge CLK_SYS);
        START <= 1'b1;
        @(posedge CLK_SYS);
        START <= 1'b0;
        for (int k = 0; k < 95000 && DONE !== 1'b1; k++) @(posedge CLK_SYS);
        chk_bit(1'b1, DONE);
        chk_bit(1'b1, VERIFY_PASS);
        chk_val(16'(ones_exp), {6'h00, ONES_RESULT});
        chk_val(16'(zeros_exp), {6'h00, ZEROS_RESULT});
        chk_val(16'h0012, 16'(mrc));
        chk_val(16'h0002, 16'(stores));
      end else begin
        for (int k = 0; k < 4000 && wr_cnt < cur_n; k++) @(posedge CLK_SYS);
        repeat (100) @(posedge CLK_SYS);
        chk_val(16'(cur_n), 16'(wr_cnt));
        chk_val(16'h0001, 16'(stores));
      end
    end
    // Reset in the idle state after a run
    RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    chk_idle();
    RST <= 1'b0;
    close_out();
  end

  initial begin
    #(CLK_PERIOD_NS * 99000);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
